// file: rtl/hrc_pkg.sv
// Constants shared by the hook release control block.
package hrc_pkg;
	// Register addresses on the serial control port.
	localparam logic [5:0] ADDR_CTRL = 6'h05;
	localparam logic [5:0] ADDR_STATUS = 6'h06;
	localparam logic [5:0] ADDR_TX_SAMPLE = 6'h07;
	localparam logic [5:0] ADDR_RX_SAMPLE = 6'h08;
	localparam logic [5:0] ADDR_HOOK_PRIMARY = 6'h10;
	localparam logic [5:0] ADDR_HOOK_SECONDARY = 6'h1f;
	localparam logic [5:0] ADDR_HOOK_RELEASE_CONFIG = 6'h3b;
	// Field positions of the control register.
	localparam int CTRL_OFFHOOK = 0;
	localparam int CTRL_RING_GROUND = 1;
	localparam int CTRL_TIP_GROUND_EN = 2;
	localparam int CTRL_IRQ_SEL = 3;
	localparam int CTRL_SLEEP = 4;
	localparam int CTRL_GCI_MODE = 5;
	// Field positions of the hook speed registers.
	localparam int HOOK_PRIMARY_BIT = 3;
	localparam int LINE_MODE_COMPANION_BIT = 1;
	localparam int HOOK_SECONDARY_BIT = 3;
	// Field positions of the hook release configuration register.
	localparam int CFG_QUENCH_TIME_HI = 6;
	localparam int CFG_QUENCH_TIME_LO = 4;
	localparam int CFG_RX_GAIN_TRIM = 2;
	localparam int CFG_GUARDED_CLEAR_EN = 1;
	localparam logic [7:0] CFG_WRITE_MASK = 8'h56;
	// Field positions of the status register.
	localparam int STAT_LOOP_CURRENT = 0;
	localparam int STAT_RELEASING = 1;
	localparam int STAT_TIP_SENSE = 2;
	localparam int STAT_RING = 3;
	// Reset values.
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [7:0] RST_CONFIG = 8'h00;
	localparam logic [7:0] RST_SAMPLE = 8'h00;
	localparam logic RST_BIT = 1'b0;
	// Serial frame layout.
	localparam int FRAME_BITS = 16;
	localparam int CMD_READ_BIT = 7;
	// Release times and the system clock rate.
	localparam int CLK_HZ = 20_000_000;
	localparam real FAST_RELEASE_MS = 0.5;
	localparam real MID_RELEASE_MS = 3.0;
	localparam real SLOW_RELEASE_MS = 26.0;
	// The fast release must finish in under its bound, so two pipeline cycles and one more come off.
	localparam int FAST_RELEASE_CYC = int'($floor(FAST_RELEASE_MS * CLK_HZ / 1000.0)) - 3;
	localparam int MID_RELEASE_CYC = int'($floor(MID_RELEASE_MS * CLK_HZ / 1000.0));
	localparam int SLOW_RELEASE_CYC = int'($floor(SLOW_RELEASE_MS * CLK_HZ / 1000.0));
	localparam int RELEASE_CNT_W = 20;
	// Highway bit period in system clocks for each format.
	localparam logic [1:0] PCM_BIT_CYC = 2'h1;
	localparam logic [1:0] GCI_BIT_CYC = 2'h2;

	typedef enum logic [1:0] {
		HOOK_ON = 2'b00,
		HOOK_OFF = 2'b01,
		HOOK_RELEASING = 2'b10
	} hrc_hook_state_type;
endpackage

// file: rtl/hrc_ser_if.sv
// Carrier between the serial port slave and the register bank.
`timescale 1ns/1ps
interface hrc_ser_if;
	logic [5:0] rd_addr;
	logic [7:0] rd_data;
	logic wr_done;
	logic [5:0] wr_addr;
	logic [7:0] wr_data;
	modport slave (output rd_addr, input rd_data, output wr_done, output wr_addr, output wr_data);
	modport bank (input rd_addr, output rd_data, input wr_done, input wr_addr, input wr_data);
endinterface

// file: rtl/hrc_ser_slave.sv
// Serial control port slave running on the serial clock.
`timescale 1ns/1ps
module hrc_ser_slave (
	// Reset from the system side, used only as a constant clear.
	input wire logic sys_rst_i,
	// Serial pins.
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic sdi_i,
	output logic sdo_o,
	output logic sdo_oe_n_o,
	output logic cascade_o,
	// Register bank side.
	hrc_ser_if.slave bus
);
	logic [4:0] cnt_r;
	logic [6:0] shift_r;
	logic [7:0] cmd_r;
	logic [2:0] bit_idx;

	assign bus.rd_addr = cmd_r[5:0];
	assign bit_idx = 3'(5'd15 - cnt_r);

	// Raising the select clears the frame, so clocks and data are ignored while it is high.
	always_ff @(posedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			cnt_r <= 5'h00;
		end else if (cnt_r != 5'(hrc_pkg::FRAME_BITS)) begin
			cnt_r <= cnt_r + 5'h01;
		end
	end

	// Input bits are captured on the rising clock edge.
	always_ff @(posedge sclk_i) begin
		shift_r <= {shift_r[5:0], sdi_i};
	end

	// The data input is passed on to the next device in the chain.
	always_ff @(posedge sclk_i) begin
		cascade_o <= sdi_i;
	end

	always_ff @(posedge sclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cmd_r <= 8'h00;
			bus.wr_done <= 1'b0;
			bus.wr_addr <= 6'h00;
			bus.wr_data <= 8'h00;
		end else if (cs_n_i == 1'b0) begin
			if (cnt_r == 5'h00) begin
				bus.wr_done <= 1'b0;
			end
			if (cnt_r == 5'h07) begin
				cmd_r <= {shift_r, sdi_i};
			end
			if (cnt_r == 5'h0f && !cmd_r[hrc_pkg::CMD_READ_BIT]) begin
				bus.wr_addr <= cmd_r[5:0];
				bus.wr_data <= {shift_r, sdi_i};
				bus.wr_done <= 1'b1;
			end
		end
	end

	// Read data leaves on the falling edge, most significant bit first.
	always_ff @(negedge sclk_i) begin
		if (cnt_r >= 5'h08 && cnt_r < 5'(hrc_pkg::FRAME_BITS)) begin
			sdo_o <= bus.rd_data[bit_idx];
		end else begin
			sdo_o <= 1'b0;
		end
	end

	// The output driver is released whenever the select is high.
	always_ff @(negedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			sdo_oe_n_o <= 1'b1;
		end else begin
			sdo_oe_n_o <= !(cmd_r[hrc_pkg::CMD_READ_BIT] && cnt_r >= 5'h08);
		end
	end
endmodule

// file: rtl/hrc_top.sv
// Hook release control register bank and host pin logic.
`timescale 1ns/1ps
module hrc_top #(
	parameter int FAST_RELEASE_CYC = hrc_pkg::FAST_RELEASE_CYC,
	parameter int MID_RELEASE_CYC = hrc_pkg::MID_RELEASE_CYC,
	parameter int SLOW_RELEASE_CYC = hrc_pkg::SLOW_RELEASE_CYC
) (
	// Master clock and reset.
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Serial control port.
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic sdi_i,
	output logic sdo_o,
	output logic sdo_oe_n_o,
	output logic serial_in_cascade_out_o,
	// Highway.
	input wire logic frame_sync_in_i,
	input wire logic highway_rx_in_i,
	output logic highway_tx_out_o,
	// Line side status inputs.
	input wire logic ring_active_i,
	input wire logic tip_ground_sense_i,
	input wire logic speaker_pwm_i,
	input wire logic irq_req_i,
	// Line side controls.
	output logic ring_detect_n_o,
	output logic speaker_or_irq_pin_o,
	output logic ring_ground_relay_o,
	output logic tip_ground_relay_en_o,
	output logic loop_current_o,
	output logic guarded_clear_draw_o,
	output logic rx_gain_trim_o,
	output logic sleep_o
);
	hrc_ser_if ser ();

	logic [7:0] ctrl_r;
	logic [7:0] cfg_r;
	logic hook_primary_r;
	logic line_mode_companion_r;
	logic hook_secondary_r;
	logic [7:0] tx_sample_r;
	logic [7:0] rx_sample_r;
	logic [7:0] rx_shift_r;
	logic [7:0] tx_shift_r;
	logic [2:0] cs_sync_r;
	logic [1:0] fs_sync_r;
	logic fs_prev_r;
	logic [1:0] rx_sync_r;
	logic [1:0] ring_sync_r;
	logic [1:0] tip_sync_r;
	logic [1:0] pwm_sync_r;
	logic [1:0] irq_sync_r;
	logic [2:0] hw_bit_r;
	logic [1:0] hw_div_r;
	logic hw_busy_r;
	hrc_pkg::hrc_hook_state_type hook_r;
	logic [hrc_pkg::RELEASE_CNT_W-1:0] rel_cnt_r;
	logic [hrc_pkg::RELEASE_CNT_W-1:0] rel_len;
	logic [7:0] status;
	logic wr_en;
	logic hw_step;
	logic [1:0] hw_period;

	hrc_ser_slave u_ser (
		.sys_rst_i(sys_rst_i),
		.sclk_i(sclk_i),
		.cs_n_i(cs_n_i),
		.sdi_i(sdi_i),
		.sdo_o(sdo_o),
		.sdo_oe_n_o(sdo_oe_n_o),
		.cascade_o(serial_in_cascade_out_o),
		.bus(ser.slave)
	);

	// Pin synchronisers.
	always_ff @(posedge clk_i) begin
		cs_sync_r <= {cs_sync_r[1:0], cs_n_i};
		fs_sync_r <= {fs_sync_r[0], frame_sync_in_i};
		rx_sync_r <= {rx_sync_r[0], highway_rx_in_i};
		ring_sync_r <= {ring_sync_r[0], ring_active_i};
		tip_sync_r <= {tip_sync_r[0], tip_ground_sense_i};
		pwm_sync_r <= {pwm_sync_r[0], speaker_pwm_i};
		irq_sync_r <= {irq_sync_r[0], irq_req_i};
	end

	// A write is applied once the frame ends; its fields are frozen by then.
	assign wr_en = cs_sync_r[1] && !cs_sync_r[2] && ser.wr_done;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ctrl_r <= hrc_pkg::RST_CTRL;
			cfg_r <= hrc_pkg::RST_CONFIG;
			hook_primary_r <= hrc_pkg::RST_BIT;
			line_mode_companion_r <= hrc_pkg::RST_BIT;
			hook_secondary_r <= hrc_pkg::RST_BIT;
			tx_sample_r <= hrc_pkg::RST_SAMPLE;
		end else if (wr_en) begin
			if (ser.wr_addr == hrc_pkg::ADDR_CTRL) begin
				ctrl_r <= ser.wr_data;
			end else if (ser.wr_addr == hrc_pkg::ADDR_TX_SAMPLE) begin
				tx_sample_r <= ser.wr_data;
			end else if (ser.wr_addr == hrc_pkg::ADDR_HOOK_PRIMARY) begin
				hook_primary_r <= ser.wr_data[hrc_pkg::HOOK_PRIMARY_BIT];
				line_mode_companion_r <= ser.wr_data[hrc_pkg::LINE_MODE_COMPANION_BIT];
			end else if (ser.wr_addr == hrc_pkg::ADDR_HOOK_SECONDARY) begin
				hook_secondary_r <= ser.wr_data[hrc_pkg::HOOK_SECONDARY_BIT];
			end else if (ser.wr_addr == hrc_pkg::ADDR_HOOK_RELEASE_CONFIG) begin
				cfg_r <= ser.wr_data & hrc_pkg::CFG_WRITE_MASK;
			end
		end
	end

	// Status image.
	always_comb begin
		status = 8'h00;
		status[hrc_pkg::STAT_LOOP_CURRENT] = loop_current_o;
		status[hrc_pkg::STAT_RELEASING] = (hook_r == hrc_pkg::HOOK_RELEASING);
		status[hrc_pkg::STAT_TIP_SENSE] = tip_sync_r[1];
		status[hrc_pkg::STAT_RING] = ring_sync_r[1];
	end

	// Read mux; unmapped addresses read zero.
	always_comb begin
		ser.rd_data = 8'h00;
		if (ser.rd_addr == hrc_pkg::ADDR_CTRL) begin
			ser.rd_data = ctrl_r;
		end else if (ser.rd_addr == hrc_pkg::ADDR_STATUS) begin
			ser.rd_data = status;
		end else if (ser.rd_addr == hrc_pkg::ADDR_TX_SAMPLE) begin
			ser.rd_data = tx_sample_r;
		end else if (ser.rd_addr == hrc_pkg::ADDR_RX_SAMPLE) begin
			ser.rd_data = rx_sample_r;
		end else if (ser.rd_addr == hrc_pkg::ADDR_HOOK_PRIMARY) begin
			ser.rd_data[hrc_pkg::HOOK_PRIMARY_BIT] = hook_primary_r;
			ser.rd_data[hrc_pkg::LINE_MODE_COMPANION_BIT] = line_mode_companion_r;
		end else if (ser.rd_addr == hrc_pkg::ADDR_HOOK_SECONDARY) begin
			ser.rd_data[hrc_pkg::HOOK_SECONDARY_BIT] = hook_secondary_r;
		end else if (ser.rd_addr == hrc_pkg::ADDR_HOOK_RELEASE_CONFIG) begin
			ser.rd_data = cfg_r;
		end
	end

	// Release length chosen from the hook speed bits and the quench field.
	always_comb begin
		rel_len = hrc_pkg::RELEASE_CNT_W'(FAST_RELEASE_CYC);
		if (hook_primary_r && cfg_r[hrc_pkg::CFG_QUENCH_TIME_HI] &&
				cfg_r[hrc_pkg::CFG_QUENCH_TIME_LO]) begin
			rel_len = hrc_pkg::RELEASE_CNT_W'(SLOW_RELEASE_CYC);
		end else if (!hook_primary_r && hook_secondary_r &&
				!cfg_r[hrc_pkg::CFG_QUENCH_TIME_HI] && !cfg_r[hrc_pkg::CFG_QUENCH_TIME_LO]) begin
			rel_len = hrc_pkg::RELEASE_CNT_W'(MID_RELEASE_CYC);
		end
	end

	// Hook state: the release runs from off-hook clear until the release count runs out; loop current then drops.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			hook_r <= hrc_pkg::HOOK_ON;
			rel_cnt_r <= '0;
		end else begin
			case (hook_r)
				hrc_pkg::HOOK_ON: begin
					if (ctrl_r[hrc_pkg::CTRL_OFFHOOK]) begin
						hook_r <= hrc_pkg::HOOK_OFF;
					end
				end
				hrc_pkg::HOOK_OFF: begin
					if (!ctrl_r[hrc_pkg::CTRL_OFFHOOK]) begin
						hook_r <= hrc_pkg::HOOK_RELEASING;
						rel_cnt_r <= rel_len;
					end
				end
				hrc_pkg::HOOK_RELEASING: begin
					if (ctrl_r[hrc_pkg::CTRL_OFFHOOK]) begin
						hook_r <= hrc_pkg::HOOK_OFF;
					end else if (rel_cnt_r <= hrc_pkg::RELEASE_CNT_W'(1)) begin
						hook_r <= hrc_pkg::HOOK_ON;
					end else begin
						rel_cnt_r <= rel_cnt_r - hrc_pkg::RELEASE_CNT_W'(1);
					end
				end
				default: begin
					hook_r <= hrc_pkg::HOOK_ON;
				end
			endcase
		end
	end

	// Highway: a frame sync rise starts eight bit periods, MSB first; the highway rests between frames.
	assign hw_period = ctrl_r[hrc_pkg::CTRL_GCI_MODE] ? hrc_pkg::GCI_BIT_CYC : hrc_pkg::PCM_BIT_CYC;
	assign hw_step = (hw_div_r == hw_period - 2'h1);

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			fs_prev_r <= 1'b0;
			hw_busy_r <= 1'b0;
			hw_bit_r <= 3'h0;
			hw_div_r <= 2'h0;
			tx_shift_r <= hrc_pkg::RST_SAMPLE;
			rx_shift_r <= hrc_pkg::RST_SAMPLE;
			rx_sample_r <= hrc_pkg::RST_SAMPLE;
			highway_tx_out_o <= 1'b0;
		end else begin
			fs_prev_r <= fs_sync_r[1];
			if (fs_sync_r[1] && !fs_prev_r) begin
				hw_busy_r <= 1'b1;
				hw_bit_r <= 3'h0;
				hw_div_r <= 2'h0;
				tx_shift_r <= {tx_sample_r[6:0], 1'b0};
				highway_tx_out_o <= tx_sample_r[7];
			end else if (hw_busy_r && hw_step) begin
				hw_div_r <= 2'h0;
				hw_bit_r <= hw_bit_r + 3'h1;
				rx_shift_r <= {rx_shift_r[6:0], rx_sync_r[1]};
				tx_shift_r <= {tx_shift_r[6:0], 1'b0};
				highway_tx_out_o <= tx_shift_r[7];
				if (hw_bit_r == 3'h7) begin
					rx_sample_r <= {rx_shift_r[6:0], rx_sync_r[1]};
					hw_busy_r <= 1'b0;
				end
			end else if (hw_busy_r) begin
				hw_div_r <= hw_div_r + 2'h1;
			end
		end
	end

	// Line side outputs.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ring_detect_n_o <= 1'b1;
			speaker_or_irq_pin_o <= 1'b0;
			ring_ground_relay_o <= 1'b0;
			tip_ground_relay_en_o <= 1'b0;
			loop_current_o <= 1'b0;
			guarded_clear_draw_o <= 1'b0;
			rx_gain_trim_o <= 1'b0;
			sleep_o <= 1'b0;
		end else begin
			ring_detect_n_o <= !ring_sync_r[1];
			speaker_or_irq_pin_o <= ctrl_r[hrc_pkg::CTRL_IRQ_SEL] ? !irq_sync_r[1] :
				pwm_sync_r[1];
			ring_ground_relay_o <= ctrl_r[hrc_pkg::CTRL_RING_GROUND];
			tip_ground_relay_en_o <= ctrl_r[hrc_pkg::CTRL_TIP_GROUND_EN];
			loop_current_o <= (hook_r != hrc_pkg::HOOK_ON) ||
				ctrl_r[hrc_pkg::CTRL_OFFHOOK];
			guarded_clear_draw_o <= cfg_r[hrc_pkg::CFG_GUARDED_CLEAR_EN] &&
				line_mode_companion_r && (hook_r == hrc_pkg::HOOK_ON) &&
				!ctrl_r[hrc_pkg::CTRL_OFFHOOK];
			rx_gain_trim_o <= cfg_r[hrc_pkg::CFG_RX_GAIN_TRIM];
			sleep_o <= ctrl_r[hrc_pkg::CTRL_SLEEP];
		end
	end
endmodule

// file: bench/hrc_top_assertions.sv
// Port checker for the hook release control top.
`timescale 1ns/1ps
module hrc_top_assertions #(
	parameter int FAST_RELEASE_CYC = 5,
	parameter int MID_RELEASE_CYC = 20,
	parameter int SLOW_RELEASE_CYC = 60
) (
	// Clocks and reset.
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic sclk_i,
	// Serial port.
	input wire logic cs_n_i,
	input wire logic sdi_i,
	input wire logic sdo_oe_n_o,
	input wire logic serial_in_cascade_out_o,
	// Line side.
	input wire logic ring_active_i,
	input wire logic speaker_pwm_i,
	input wire logic irq_req_i,
	input wire logic ring_detect_n_o,
	input wire logic speaker_or_irq_pin_o,
	input wire logic ring_ground_relay_o,
	input wire logic loop_current_o,
	input wire logic guarded_clear_draw_o,
	input wire logic rx_gain_trim_o,
	input wire logic sleep_o
);
	chk_cs_release:
	assert property (@(posedge clk_i) disable iff (sys_rst_i)
		cs_n_i && $past(cs_n_i) |-> sdo_oe_n_o) else $error("sdo driven while deselected");
	chk_cascade_copy:
	assert property (@(negedge sclk_i) disable iff (sys_rst_i)
		!cs_n_i |-> serial_in_cascade_out_o == sdi_i) else $error("cascade output wrong");
	chk_ring_low:
	assert property (@(posedge clk_i) disable iff (sys_rst_i)
		ring_active_i [*5] |-> !ring_detect_n_o) else $error("ring detect not low");
	chk_ring_high:
	assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!ring_active_i [*5] |-> ring_detect_n_o) else $error("ring detect not high");
	chk_pin_low:
	assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(!speaker_pwm_i && irq_req_i) [*5] |-> !speaker_or_irq_pin_o) else $error("pin not low");
	chk_pin_high:
	assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(speaker_pwm_i && !irq_req_i) [*5] |-> speaker_or_irq_pin_o) else $error("pin not high");
	chk_gc_onhook:
	assert property (@(posedge clk_i) disable iff (sys_rst_i)
		guarded_clear_draw_o && $past(guarded_clear_draw_o) |-> !loop_current_o)
		else $error("guarded clear while off hook");
	chk_gain_hold:
	assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$changed(rx_gain_trim_o) |-> cs_n_i && $past(cs_n_i, 2)) else $error("gain changed unwritten");
	chk_relay_hold:
	assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$changed(ring_ground_relay_o) |-> $past(cs_n_i) && $past(cs_n_i, 2))
		else $error("relay changed unwritten");
	chk_reset_clear:
	assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$fell(sys_rst_i) |-> !(sleep_o || loop_current_o || ring_ground_relay_o || rx_gain_trim_o))
		else $error("outputs not cleared by reset");
endmodule
bind hrc_top hrc_top_assertions #(.FAST_RELEASE_CYC(FAST_RELEASE_CYC),
	.MID_RELEASE_CYC(MID_RELEASE_CYC), .SLOW_RELEASE_CYC(SLOW_RELEASE_CYC)) hrc_top_assertions_i (
	.clk_i(clk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i), .sdi_i(sdi_i),
	.sdo_oe_n_o(sdo_oe_n_o), .serial_in_cascade_out_o(serial_in_cascade_out_o),
	.ring_active_i(ring_active_i), .speaker_pwm_i(speaker_pwm_i), .irq_req_i(irq_req_i),
	.ring_detect_n_o(ring_detect_n_o), .speaker_or_irq_pin_o(speaker_or_irq_pin_o),
	.ring_ground_relay_o(ring_ground_relay_o), .loop_current_o(loop_current_o),
	.guarded_clear_draw_o(guarded_clear_draw_o), .rx_gain_trim_o(rx_gain_trim_o),
	.sleep_o(sleep_o));

// file: bench/hrc_host_model.sv
// Host controller model for the serial port and the highway.
`timescale 1ns/1ps
module hrc_host_model (
	// Master clock.
	input wire logic clk_i,
	// Serial port.
	input wire logic sdo_i,
	input wire logic sdo_oe_n_i,
	output logic sclk_o,
	output logic cs_n_o,
	output logic sdi_o,
	// Highway.
	input wire logic tx_i,
	output logic fs_o,
	output logic rx_o
);
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b0;
		sdi_o = 1'b0;
		fs_o = 1'b0;
		rx_o = 1'b0;
		// A clean rise of the select at start-up releases the data output.
		#1 cs_n_o = 1'b1;
	end
	// One frame of command and data, MSB first; the serial clock runs only inside it.
	task automatic xfer(input logic [15:0] w, output logic [7:0] r);
		cs_n_o = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			#1 sdi_o = w[i];
			#2 sclk_o = 1'b1;
			if (i < 8) r[i] = sdo_oe_n_i ? 1'bx : sdo_i;
			#3 sclk_o = 1'b0;
		end
		#2 cs_n_o = 1'b1;
		sdi_o = ~sdi_o;
	endtask
	// One highway frame: frame sync pulse, then the transmit pin is sampled every clock.
	task automatic frame(input logic rxb, output logic [23:0] s);
		@(posedge clk_i);
		fs_o <= 1'b1;
		rx_o <= rxb;
		for (int i = 0; i < 24; i++) begin
			@(posedge clk_i);
			s = {s[22:0], tx_i};
			if (i == 3) fs_o <= 1'b0;
		end
		rx_o <= 1'b0;
	endtask
endmodule

// file: bench/hrc_top_bench.sv
// Self-checking bench for the hook release control top.
`timescale 1ns/1ps
module hrc_top_bench;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic ring_active_i = 1'b0;
	logic tip_ground_sense_i = 1'b0;
	logic speaker_pwm_i = 1'b0;
	logic irq_req_i = 1'b0;
	logic sclk_i, cs_n_i, sdi_i, frame_sync_in_i, highway_rx_in_i, sdo_o, sdo_oe_n_o;
	logic serial_in_cascade_out_o, highway_tx_out_o, ring_detect_n_o, speaker_or_irq_pin_o;
	logic ring_ground_relay_o, tip_ground_relay_en_o, loop_current_o, guarded_clear_draw_o;
	logic rx_gain_trim_o, sleep_o;
	int mismatches = 0;
	int checks_done = 0;
	int cnt [3] = '{5, 20, 60};
	logic [7:0] pri [3] = '{8'h00, 8'h00, 8'h08};
	logic [7:0] sec [3] = '{8'h00, 8'h08, 8'h00};
	logic [7:0] cfg [3] = '{8'h00, 8'h00, 8'h50};

	always #25 clk_i = ~clk_i;

	hrc_top #(.FAST_RELEASE_CYC(5), .MID_RELEASE_CYC(20), .SLOW_RELEASE_CYC(60)) hrc_top_i (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i), .sdi_i(sdi_i),
		.sdo_o(sdo_o), .sdo_oe_n_o(sdo_oe_n_o), .serial_in_cascade_out_o(serial_in_cascade_out_o),
		.frame_sync_in_i(frame_sync_in_i), .highway_rx_in_i(highway_rx_in_i),
		.highway_tx_out_o(highway_tx_out_o), .ring_active_i(ring_active_i),
		.tip_ground_sense_i(tip_ground_sense_i), .speaker_pwm_i(speaker_pwm_i),
		.irq_req_i(irq_req_i), .ring_detect_n_o(ring_detect_n_o),
		.speaker_or_irq_pin_o(speaker_or_irq_pin_o), .ring_ground_relay_o(ring_ground_relay_o),
		.tip_ground_relay_en_o(tip_ground_relay_en_o), .loop_current_o(loop_current_o),
		.guarded_clear_draw_o(guarded_clear_draw_o), .rx_gain_trim_o(rx_gain_trim_o),
		.sleep_o(sleep_o));

	hrc_host_model hrc_host_model_i (
		.clk_i(clk_i), .sdo_i(sdo_o), .sdo_oe_n_i(sdo_oe_n_o), .sclk_o(sclk_i), .cs_n_o(cs_n_i),
		.sdi_o(sdi_i), .tx_i(highway_tx_out_o), .fs_o(frame_sync_in_i), .rx_o(highway_rx_in_i));

	task automatic check(input string n, input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", n, exp, got);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic [7:0] r;
		hrc_host_model_i.xfer({2'b00, a, d}, r);
		repeat (8) @(posedge clk_i);
	endtask

	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		hrc_host_model_i.xfer({2'b10, a, 8'h00}, d);
		repeat (8) @(posedge clk_i);
	endtask

	initial begin
		logic [7:0] d;
		logic [23:0] s;
		int n;
		repeat (6) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		check("oe idle", sdo_oe_n_o, 1);
		wr(6'h3b, 8'hff);
		rd(6'h3b, d);
		check("cfg mask", d, 8'h56);
		check("gain", rx_gain_trim_o, 1);
		rd(6'h20, d);
		check("unmapped", d, 0);
		for (int k = 0; k < 3; k++) begin
			wr(6'h10, pri[k]);
			wr(6'h1f, sec[k]);
			wr(6'h3b, cfg[k]);
			wr(6'h05, 8'h01);
			check("off hook", loop_current_o, 1);
			rd(6'h3b, d);
			check("cfg hold", d, cfg[k]);
			hrc_host_model_i.xfer(16'h0500, d);
			n = 0;
			while (loop_current_o === 1'b1 && n < 300) begin
				@(posedge clk_i);
				n++;
			end
			check("release", n >= cnt[k] + 2 && n <= cnt[k] + 10, 1);
			if (n == 300) complete_run();
			repeat (8) @(posedge clk_i);
		end
		wr(6'h10, 8'h02);
		wr(6'h3b, 8'h02);
		check("gc draw", guarded_clear_draw_o, 1);
		wr(6'h3b, 8'h00);
		check("gc off", guarded_clear_draw_o, 0);
		wr(6'h05, 8'h0e);
		check("relays", {ring_ground_relay_o, tip_ground_relay_en_o}, 2'b11);
		irq_req_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		check("irq pin", speaker_or_irq_pin_o, 0);
		wr(6'h05, 8'h00);
		speaker_pwm_i <= 1'b1;
		irq_req_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		check("spk pin", speaker_or_irq_pin_o, 1);
		ring_active_i <= 1'b1;
		tip_ground_sense_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		check("ring", ring_detect_n_o, 0);
		rd(6'h06, d);
		check("tip sense", d[3:2], 2'b11);
		ring_active_i <= 1'b0;
		wr(6'h07, 8'ha5);
		hrc_host_model_i.frame(1'b1, s);
		n = 0;
		for (int i = 0; i <= 16; i++) begin
			if (s[i+:8] === 8'ha5) n = 1;
		end
		check("tx word", n, 1);
		rd(6'h08, d);
		check("rx word", d, 8'hff);
		wr(6'h05, 8'h20);
		wr(6'h07, 8'h3c);
		hrc_host_model_i.frame(1'b0, s);
		n = 0;
		for (int i = 0; i <= 8; i++) begin
			if (s[i+:16] === 16'h0ff0) n = 1;
		end
		check("gci tx word", n, 1);
		rd(6'h08, d);
		check("gci rx word", d, 8'h00);
		wr(6'h05, 8'h10);
		wr(6'h3b, 8'h04);
		check("sleep", sleep_o, 1);
		sys_rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		check("sleep ends", {sleep_o, rx_gain_trim_o}, 0);
		rd(6'h3b, d);
		check("cfg reset", d, 8'h00);
		complete_run();
	end
endmodule
